// ===== dout_group_defines.svh
`ifndef DOUT_GROUP_DEFINES_SVH
`define DOUT_GROUP_DEFINES_SVH

// Command codes carried in the command field
`define CMD_READ_ID       8'h20
`define CMD_READ_DATA     8'h21
`define CMD_READ_STATUS   8'h28
`define CMD_WRITE_DATA    8'h48
`define CMD_PREPARE       8'h60
`define CMD_ARM_SYNC      8'h69
`define CMD_DIAG_SYNC     8'h6B
`define CMD_DISABLE_OUT   8'h6C
`define CMD_DEVICE_RESET  8'h6F

// Condition codes
`define CC_NOT_ATTACHED   3'h0
`define CC_BUSY           3'h1
`define CC_DATA_CHECK     3'h5
`define CC_OK             3'h7

// Status word field positions (bits of the 16-bit word, bit 15 is the first bit)
`define ST_IRQ_HI         15
`define ST_IRQ_LO         14
`define ST_DIAG_SYNC      11
`define ST_DISABLE        10
`define ST_SYNC_ARMED     9

// Register bus offsets
`define REG_INT_STATUS    4'h0
`define REG_INT_MASK      4'h1
`define REG_GROUP_STATE   4'h2
`define REG_PREPARE       4'h3

// Reset values
`define RST_DATA          16'h0000
`define RST_LEVEL         2'h0

`endif

// ===== dout_group_pkg.sv
package dout_group_pkg;
    // Sequencer states for a command
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } cmdState_t;
    typedef logic [15:0] word_t;
endpackage

// ===== dout_irq_regs.sv
`timescale 1ns/100ps
`include "dout_group_defines.svh"
// Sticky event status with mask, write-one-to-clear
module dout_irq_regs #(
    parameter int NEVT = 3
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            reset,
    // Events
    input  wire logic [NEVT-1:0] evtPulse,
    // Register access
    input  wire logic            statClear,
    input  wire logic            maskWrite,
    input  wire logic [NEVT-1:0] wrData,
    // State
    output logic      [NEVT-1:0] status,
    output logic      [NEVT-1:0] mask,
    output logic                 irqOut
);
    logic [NEVT-1:0] status_ff;     // Sticky bits
    logic [NEVT-1:0] mask_ff;       // Enables

    // Per-bit sticky flag; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < NEVT; gi++) begin : g_bit
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    status_ff[gi] <= 1'b0;
                end else if (evtPulse[gi]) begin
                    status_ff[gi] <= 1'b1;
                end else if (statClear && wrData[gi]) begin
                    status_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mask_ff <= '0;
        end else if (maskWrite) begin
            mask_ff <= wrData;
        end
    end

    assign status = status_ff;
    assign mask   = mask_ff;
    assign irqOut = |(status_ff & mask_ff);
endmodule

// ===== digital_output_group_control.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`include "dout_group_defines.svh"
module digital_output_group_control
#(
    parameter logic [15:0] ID_WORD = 16'h5A5A  // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Channel command port
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] cmdData,
    input  wire logic        parityErr,
    output logic             cmdDone,
    output logic [2:0]       condCode,
    output dout_group_pkg::word_t rspData,
    // Interrupt toward channel
    output logic             attnReq,
    output logic [1:0]       attnLevel,
    input  wire logic        attnAccept,
    // User equipment
    output logic [15:0]      dataOut,
    output logic             readyOut,
    input  wire logic        syncIn,
    // Register bus
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdata,
    output logic             irqOut
);
    import dout_group_pkg::*;

    cmdState_t   state_ff;          // Command sequencer
    logic [7:0]  code_ff;           // Latched command
    logic [15:0] imm_ff;            // Latched immediate data
    logic        chk_ff;            // Latched data check
    logic [15:0] data_ff;           // Output data register
    logic [1:0]  level_ff;          // Prepared level
    logic        ienable_ff;        // Prepared I bit
    logic        armed_ff;          // External-sync mode armed
    logic        diagSync_ff;       // Diagnostic sync mode
    logic        disable_ff;        // Outputs disabled
    logic        ready_ff;          // Ready line
    logic        pend_ff;           // Interrupt pending
    logic        sync_ff;           // Effective sync, last cycle
    logic        done_ff;           // Answer strobe
    logic [2:0]  cc_ff;             // Condition code of the last answer
    logic [15:0] rsp_ff;            // Immediate data of the last answer
    logic [15:0] regRdata_ff;       // Register read data, one cycle wide
    logic        effSync;           // Sync as seen by the group
    logic        syncFall;          // Handshake completion event
    logic        diagPost;          // Diagnostic interrupt event
    logic        exec;              // Command executes this cycle
    logic        busyGuard;         // Busy for arm/diag/disable
    logic        wrBusy;            // Busy for write
    logic [2:0]  evtStatus;
    logic [2:0]  evtMask;

    // Diag modes cut the user sync; diag-sync holds it active
    always_comb begin
        if (diagSync_ff) begin
            effSync = 1'b1;
        end else if (disable_ff) begin
            effSync = 1'b0;
        end else begin
            effSync = syncIn;
        end
    end

    // Falling sync only counts in armed mode with ready up
    assign syncFall = armed_ff && ready_ff && sync_ff && !effSync && !pend_ff;
    assign diagPost = diagSync_ff && armed_ff && disable_ff && !pend_ff;
    assign exec     = (state_ff == ST_EXEC) && !chk_ff;
    assign busyGuard = pend_ff;
    assign wrBusy    = pend_ff || (armed_ff && ready_ff);

    // Command sequencer: capture, execute, answer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            code_ff  <= 8'h00;
            imm_ff   <= 16'h0000;
            chk_ff   <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (cmdValid) begin
                        state_ff <= ST_EXEC;
                        code_ff  <= cmdCode;
                        imm_ff   <= cmdData;
                        chk_ff   <= parityErr;
                    end
                end
                ST_EXEC: state_ff <= ST_DONE;
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Answer: condition code and immediate data back
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
            cc_ff   <= `CC_OK;
            rsp_ff  <= 16'h0000;
        end else begin
            done_ff <= (state_ff == ST_EXEC);
            if (state_ff == ST_EXEC) begin
                rsp_ff <= 16'h0000;
                if (chk_ff) begin
                    cc_ff <= `CC_DATA_CHECK;
                end else begin
                    case (code_ff)
                        `CMD_READ_ID: begin
                            cc_ff  <= `CC_OK;
                            rsp_ff <= ID_WORD;
                        end
                        `CMD_READ_DATA: begin
                            cc_ff  <= `CC_OK;
                            rsp_ff <= data_ff;
                        end
                        `CMD_READ_STATUS: begin
                            cc_ff  <= `CC_OK;
                            rsp_ff <= {pend_ff, pend_ff, 2'h0, diagSync_ff, disable_ff,
                                       armed_ff, 9'h0};
                        end
                        `CMD_WRITE_DATA: cc_ff <= wrBusy ? `CC_BUSY : `CC_OK;
                        `CMD_ARM_SYNC, `CMD_DIAG_SYNC, `CMD_DISABLE_OUT:
                            cc_ff <= busyGuard ? `CC_BUSY : `CC_OK;
                        `CMD_PREPARE, `CMD_DEVICE_RESET: cc_ff <= `CC_OK;
                        default: cc_ff <= `CC_NOT_ATTACHED;
                    endcase
                end
            end
        end
    end

    // Prepare: one shared level and I bit, overwritten each time
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            level_ff   <= `RST_LEVEL;
            ienable_ff <= 1'b0;
        end else if (exec && code_ff == `CMD_PREPARE) begin
            level_ff   <= imm_ff[1:0];
            ienable_ff <= imm_ff[15];
        end else if (regWr && regAddr == `REG_PREPARE) begin
            level_ff   <= regWdata[1:0];
            ienable_ff <= regWdata[15];
        end
    end

    // Data register; device reset leaves it alone
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_ff <= `RST_DATA;
        end else if (exec && code_ff == `CMD_WRITE_DATA && !wrBusy) begin
            data_ff <= imm_ff;
        end
    end

    // Modes: arm, diagnostic sync, disable; device reset clears all
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            armed_ff    <= 1'b0;
            diagSync_ff <= 1'b0;
            disable_ff  <= 1'b0;
        end else if (exec) begin
            case (code_ff)
                `CMD_ARM_SYNC:    if (!busyGuard) armed_ff <= 1'b1;
                `CMD_DIAG_SYNC:   if (!busyGuard) diagSync_ff <= 1'b1;
                `CMD_DISABLE_OUT: if (!busyGuard) disable_ff <= 1'b1;
                `CMD_DEVICE_RESET: begin
                    armed_ff    <= 1'b0;
                    diagSync_ff <= 1'b0;
                    disable_ff  <= 1'b0;
                end
                default: armed_ff <= armed_ff;
            endcase
        end
    end

    // Ready line: raised by armed write, dropped by the sync interrupt
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ready_ff <= 1'b0;
        end else if (exec && code_ff == `CMD_DEVICE_RESET) begin
            ready_ff <= 1'b0;
        end else if (syncFall || diagPost) begin
            ready_ff <= 1'b0;
        end else if (exec && code_ff == `CMD_WRITE_DATA && !wrBusy && armed_ff) begin
            ready_ff <= 1'b1;
        end
    end

    // Pending interrupt: held until accepted or device reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pend_ff <= 1'b0;
        end else if (syncFall || diagPost) begin
            pend_ff <= 1'b1;
        end else if (exec && code_ff == `CMD_DEVICE_RESET) begin
            pend_ff <= 1'b0;
        end else if (attnAccept && attnReq) begin
            pend_ff <= 1'b0;
        end
    end

    // Sync history for edge detection
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_ff <= 1'b0;
        end else begin
            sync_ff <= effSync;
        end
    end

    // Event bits: sync interrupt, diag interrupt, busy answer
    dout_irq_regs #(
        .NEVT(3)
    ) u_irq (
        .mclk     (mclk),
        .reset    (reset),
        .evtPulse ({done_ff && cc_ff == `CC_BUSY, diagPost, syncFall}),
        .statClear(regWr && regAddr == `REG_INT_STATUS),
        .maskWrite(regWr && regAddr == `REG_INT_MASK),
        .wrData   (regWdata[2:0]),
        .status   (evtStatus),
        .mask     (evtMask),
        .irqOut   (irqOut)
    );

    // Register read, one cycle later; unmapped reads zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            regRdata_ff <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `REG_INT_STATUS:  regRdata_ff <= {13'h0000, evtStatus};
                `REG_INT_MASK:    regRdata_ff <= {13'h0000, evtMask};
                `REG_GROUP_STATE: regRdata_ff <= {10'h000, pend_ff, ready_ff, disable_ff,
                                                  diagSync_ff, armed_ff, effSync};
                `REG_PREPARE:     regRdata_ff <= {ienable_ff, 13'h0000, level_ff};
                default:          regRdata_ff <= 16'h0000;
            endcase
        end else begin
            regRdata_ff <= 16'h0000;
        end
    end

    // Outputs forced low in either diagnostic mode
    assign dataOut   = (disable_ff || diagSync_ff) ? 16'h0000 : data_ff;
    assign readyOut  = ready_ff && !disable_ff && !diagSync_ff;
    assign attnReq   = pend_ff && ienable_ff;
    assign attnLevel = level_ff;
    assign cmdDone   = done_ff;
    assign condCode  = cc_ff;
    assign rspData   = rsp_ff;
    assign regRdata  = regRdata_ff;

    // Checks
    property p_write_load;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_WRITE_DATA && !wrBusy) |=> (data_ff == $past(imm_ff));
    endproperty
    a_write_load: assert property (p_write_load) else $error("write not loaded");

    property p_write_busy;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_WRITE_DATA && wrBusy) |=> $stable(data_ff) && condCode == `CC_BUSY;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("busy write changed data");

    property p_check_nochange;
        @(posedge mclk) disable iff (reset)
        (state_ff == ST_EXEC && chk_ff) |=> $stable(data_ff) && $stable(armed_ff) && condCode == `CC_DATA_CHECK;
    endproperty
    a_check_nochange: assert property (p_check_nochange) else $error("data check changed state");

    property p_ready_raise;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_WRITE_DATA && !wrBusy && armed_ff) |=> ready_ff;
    endproperty
    a_ready_raise: assert property (p_ready_raise) else $error("ready not raised");

    property p_sync_irq;
        @(posedge mclk) disable iff (reset)
        syncFall |=> pend_ff && !ready_ff;
    endproperty
    a_sync_irq: assert property (p_sync_irq) else $error("sync fall lost");

    property p_disable_zero;
        @(posedge mclk) disable iff (reset)
        disable_ff |-> dataOut == 16'h0000 && !readyOut;
    endproperty
    a_disable_zero: assert property (p_disable_zero) else $error("outputs not forced low");

    property p_devreset;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_DEVICE_RESET) |=>
            !pend_ff && !armed_ff && !disable_ff && !diagSync_ff && $stable(data_ff);
    endproperty
    a_devreset: assert property (p_devreset) else $error("device reset incomplete");

    property p_guard_busy;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_ARM_SYNC && pend_ff) |=> condCode == `CC_BUSY && $stable(armed_ff);
    endproperty
    a_guard_busy: assert property (p_guard_busy) else $error("arm not refused");

    // Latched immediate data holds through the done cycle, so no history is needed
    property p_prepare_load;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_PREPARE) |=> level_ff == imm_ff[1:0] && ienable_ff == imm_ff[15];
    endproperty
    a_prepare_load: assert property (p_prepare_load) else $error("prepare not replaced");

    property p_id_read;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_READ_ID) |=> rspData == ID_WORD && condCode == `CC_OK;
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity word wrong");

    property p_arm_set;
        @(posedge mclk) disable iff (reset)
        (exec && code_ff == `CMD_ARM_SYNC && !pend_ff) |=> armed_ff && condCode == `CC_OK;
    endproperty
    a_arm_set: assert property (p_arm_set) else $error("arm not taken");
endmodule

// ===== user_equipment_model.sv
`timescale 1ns/100ps
// Behavioural user equipment on the output, ready and sync lines
module user_equipment_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Lines from the output group
    input  wire logic [15:0] dataOut,
    input  wire logic        readyOut,
    // High makes the user answer slowly
    input  wire logic        slow,
    // Sync back to the group, and the word taken
    output logic             syncIn,
    output logic [15:0]      seenData
);
    logic [5:0] waitCnt_ff;  // Cycles since ready was seen

    // Take the word while ready stands, then drop sync to finish the handshake
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            syncIn     <= 1'b1;
            seenData   <= 16'h0000;
            waitCnt_ff <= 6'h00;
        end else if (readyOut && syncIn) begin
            if (waitCnt_ff == (slow ? 6'h1E : 6'h02)) begin
                seenData   <= dataOut;  // Lines are settled while ready is high
                syncIn     <= 1'b0;
                waitCnt_ff <= 6'h00;
            end else begin
                waitCnt_ff <= waitCnt_ff + 6'h01;
            end
        end else if (!readyOut) begin
            // Sync goes active again only after ready has dropped
            syncIn <= 1'b1;
        end
    end
endmodule

// ===== digital_output_group_control_tb.sv
`timescale 1ns/100ps
`include "dout_group_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module digital_output_group_control_tb;
    import dout_group_pkg::*;
    // Stimulus
    logic        mclk, reset, cmdValid, parityErr, attnAccept, regWr, regRd, slow;
    logic [7:0]  cmdCode;
    logic [15:0] cmdData, regWdata, v;
    logic [3:0]  regAddr;
    // Observed
    logic        cmdDone, attnReq, readyOut, syncIn, irqOut;
    logic [2:0]  condCode;
    logic [1:0]  attnLevel;
    logic [15:0] dataOut, regRdata, seen;
    word_t       rspData, rd;
    int          fail_count, n_tests;
    // Commands that a pending interrupt must refuse
    logic [7:0]  busyCmd [4] = '{`CMD_ARM_SYNC, `CMD_DIAG_SYNC, `CMD_DISABLE_OUT, `CMD_WRITE_DATA};

    digital_output_group_control digital_output_group_control_inst (
        .mclk(mclk), .reset(reset), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
        .parityErr(parityErr), .cmdDone(cmdDone), .condCode(condCode), .rspData(rspData),
        .attnReq(attnReq), .attnLevel(attnLevel), .attnAccept(attnAccept), .dataOut(dataOut),
        .readyOut(readyOut), .syncIn(syncIn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqOut(irqOut));

    user_equipment_model user_equipment_model_inst (
        .mclk(mclk), .reset(reset), .dataOut(dataOut), .readyOut(readyOut), .slow(slow),
        .syncIn(syncIn), .seenData(seen));

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One command, answer awaited under a bound, condition code compared
    task automatic cmd(input logic [7:0] c, input logic [15:0] d, input logic p, input logic [2:0] ecc);
        int i;
        @(posedge mclk);
        cmdValid  <= 1'b1;
        cmdCode   <= c;
        cmdData   <= d;
        parityErr <= p;
        @(posedge mclk);
        cmdValid  <= 1'b0;
        parityErr <= 1'b0;
        for (i = 0; i < 8 && cmdDone !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (cmdDone !== 1'b1) begin
            fail_count++;
            $display("BAD cmdDone exp 1 got 0");
            report_and_stop();
        end
        rd = rspData;
        `CHK("condCode", ecc, condCode)
    endtask

    // Register bus write, one strobe cycle
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    // Register bus read, data taken in the following cycle
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Bounded wait for the attention request
    task automatic waitAttn;
        int i;
        for (i = 0; i < 80 && attnReq !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        `CHK("attnReq", 1'b1, attnReq)
    endtask

    // Hang guard
    initial begin
        #1000000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {cmdValid, parityErr, attnAccept, regWr, regRd} = 5'h00;
        {cmdCode, cmdData, regWdata, regAddr} = 44'h0;
        fail_count = 0;
        n_tests    = 0;
        slow       = 1'b1;
        reset      = 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        cmd(`CMD_READ_ID, 16'h0000, 1'b0, `CC_OK);
        `CHK("id", 16'h5A5A, rd)
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'h0000, rd)
        cmd(`CMD_PREPARE, 16'h0003, 1'b0, `CC_OK);
        `CHK("level", 2'h3, attnLevel)
        cmd(`CMD_PREPARE, 16'h8001, 1'b0, `CC_OK);
        `CHK("level", 2'h1, attnLevel)
        rreg(`REG_PREPARE, v);
        `CHK("prepReg", 16'h8001, v)
        cmd(`CMD_WRITE_DATA, 16'h1234, 1'b1, `CC_DATA_CHECK);
        cmd(`CMD_READ_DATA, 16'h0000, 1'b0, `CC_OK);
        `CHK("readback", 16'h0000, rd)
        cmd(`CMD_WRITE_DATA, 16'hA5C3, 1'b0, `CC_OK);
        `CHK("dataOut", 16'hA5C3, dataOut)
        `CHK("readyOut", 1'b0, readyOut)
        cmd(`CMD_READ_DATA, 16'h0000, 1'b0, `CC_OK);
        `CHK("readback", 16'hA5C3, rd)
        wreg(`REG_INT_MASK, 16'h0007);
        cmd(`CMD_ARM_SYNC, 16'h0000, 1'b0, `CC_OK);
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'h0200, rd)
        cmd(`CMD_WRITE_DATA, 16'h0F0F, 1'b0, `CC_OK);
        `CHK("readyOut", 1'b1, readyOut)
        cmd(`CMD_WRITE_DATA, 16'hFFFF, 1'b0, `CC_BUSY);
        cmd(`CMD_READ_DATA, 16'h0000, 1'b0, `CC_OK);
        `CHK("readback", 16'h0F0F, rd)
        waitAttn();
        `CHK("seen", 16'h0F0F, seen)
        `CHK("readyOut", 1'b0, readyOut)
        foreach (busyCmd[k]) cmd(busyCmd[k], 16'h0000, 1'b0, `CC_BUSY);
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'hC200, rd)
        `CHK("irqOut", 1'b1, irqOut)
        wreg(`REG_INT_MASK, 16'h0000);
        rreg(`REG_INT_STATUS, v);
        `CHK("evtStatus", 16'h0005, v)
        `CHK("irqOut", 1'b0, irqOut)
        wreg(`REG_INT_MASK, 16'h0007);
        wreg(`REG_INT_STATUS, 16'h0007);
        rreg(`REG_INT_STATUS, v);
        `CHK("evtStatus", 16'h0000, v)
        `CHK("irqOut", 1'b0, irqOut)
        rreg(4'hF, v);
        `CHK("unmapped", 16'h0000, v)
        `CHK("attnReq", 1'b1, attnReq)
        @(posedge mclk);
        attnAccept <= 1'b1;
        @(posedge mclk);
        attnAccept <= 1'b0;
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'h0200, rd)
        `CHK("attnReq", 1'b0, attnReq)
        cmd(`CMD_DIAG_SYNC, 16'h0000, 1'b0, `CC_OK);
        `CHK("dataOut", 16'h0000, dataOut)
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'h0A00, rd)
        cmd(`CMD_DISABLE_OUT, 16'h0000, 1'b0, `CC_OK);
        `CHK("dataOut", 16'h0000, dataOut)
        `CHK("readyOut", 1'b0, readyOut)
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'hCE00, rd)
        rreg(`REG_GROUP_STATE, v);
        `CHK("groupState", 16'h002F, v)
        rreg(`REG_INT_STATUS, v);
        `CHK("evtStatus", 16'h0002, v)
        `CHK("irqOut", 1'b1, irqOut)
        cmd(`CMD_DEVICE_RESET, 16'h0000, 1'b0, `CC_OK);
        `CHK("attnReq", 1'b0, attnReq)
        `CHK("dataOut", 16'h0F0F, dataOut)
        cmd(`CMD_READ_STATUS, 16'h0000, 1'b0, `CC_OK);
        `CHK("status", 16'h0000, rd)
        cmd(`CMD_READ_DATA, 16'h0000, 1'b0, `CC_OK);
        `CHK("readback", 16'h0F0F, rd)
        slow <= 1'b0;
        cmd(`CMD_ARM_SYNC, 16'h0000, 1'b0, `CC_OK);
        cmd(`CMD_WRITE_DATA, 16'h00FF, 1'b0, `CC_OK);
        waitAttn();
        `CHK("seen", 16'h00FF, seen)
        report_and_stop();
    end
endmodule
